// file: wosc_pkg.sv
// Shared constants, field layouts and types of the write-only serial control
// block. Assumes a 100 MHz system clock; all widths are in bits.
package wosc_pkg;

   // System clock and diagnostic timing
   localparam longint CLK_HZ      = 100_000_000;
   localparam longint MS_PER_S    = 1000;
   localparam longint T_DIAG_MS   = 63;
   localparam longint T_REPEAT_MS = 60;

   function automatic int unsigned ms_to_cycles(input longint ms);
      longint cyc;
      cyc = (ms * CLK_HZ) / MS_PER_S;
      if (cyc < 1)
         cyc = 1;
      return int'(cyc);
   endfunction

   localparam int unsigned DIAG_CYCLES_DEF   = ms_to_cycles(T_DIAG_MS);
   localparam int unsigned REPEAT_CYCLES_DEF = ms_to_cycles(T_REPEAT_MS);

   // Serial bus framing
   localparam int         BYTE_BITS   = 8;
   localparam logic [3:0] BIT_CNT_END = 4'h8;
   localparam logic [5:0] ADDR_PREFIX = 6'h3e;
   localparam int         ADDR_PFX_MSB = 7;
   localparam int         ADDR_PFX_LSB = 2;
   localparam int         ADDR_STRAP_BIT = 1;
   localparam int         ADDR_RW_BIT  = 0;

   // Data byte layout: select code in B7..B5, payload in B4..B0
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 5;
   localparam int PAY_MSB = 4;
   localparam logic [2:0] SEL_MODE   = 3'h0;
   localparam logic [2:0] SEL_DIAG   = 3'h1;
   localparam logic [2:0] SEL_MASK   = 3'h2;
   localparam logic [2:0] SEL_GAIN_A = 3'h3;
   localparam logic [2:0] SEL_GAIN_B = 3'h4;

   // Field positions
   localparam int MODE_AMP_EN_BIT = 4;
   localparam int MODE_IN_B_BIT   = 3;
   localparam int MODE_IN_A_BIT   = 2;
   localparam int DIAG_TRIG_BIT   = 4;
   localparam int DIAG_REP_BIT    = 3;
   localparam int DIAG_CLR_BIT    = 2;
   localparam int DIAG_CAP_BIT    = 1;
   localparam int GAIN_W          = 5;
   localparam int FAULT_W         = 5;

   // Fault senses, in the bit order of the fault mask (B4..B0)
   typedef struct packed {
      logic thermal;
      logic overcurrent;
      logic supply_short;
      logic open_load;
      logic bridged_short;
   } wosc_fault_t;

   // Faults watched at all times, then output-test faults that only a diagnostic run looks at
   localparam logic [FAULT_W-1:0] FAULT_ALWAYS = 5'h18;
   localparam logic [FAULT_W-1:0] FAULT_DIAG   = 5'h07;

   // Decoded control register contents
   typedef struct packed {
      logic              amp_enable;
      logic              audio_in_b;
      logic              audio_in_a;
      logic              diag_trigger;
      logic              diag_repeat_mode;
      logic              fault_clear;
      logic              current_cap_select;
      logic [FAULT_W-1:0] fault_mask;
      logic [GAIN_W-1:0] gain_a_level;
      logic [GAIN_W-1:0] gain_b_level;
   } wosc_ctrl_t;

   localparam wosc_ctrl_t CTRL_RESET = '0;

   typedef enum {
      BUS_IDLE,
      BUS_ADDR,
      BUS_ADDR_ACK,
      BUS_DATA,
      BUS_DATA_ACK,
      BUS_WAIT_STOP
   } wosc_bus_t;

   typedef enum {
      SEQ_POWERUP,
      SEQ_IDLE,
      SEQ_RUN,
      SEQ_WAIT
   } wosc_seq_t;

endpackage

// file: wosc_top.sv
// Write-only two-wire serial slave with control registers and diagnostic
// sequencer. Assumes scl from an external master, sda resolved outside from
// sda_oe, and asynchronous fault senses from the analog section.
//
// Function
// - Bus runs at up to 400kHz serial clock; master keeps to it.
// - Answer address 111110X, X taken from the address strap pin.
// - Every byte is eight bits followed by a ninth acknowledge clock.
// - Writes only; a transfer with read/write bit one gets no answer.
// - On address match pull data low during the acknowledge clock.
// - One data byte follows, is acknowledged, then master sends STOP.
// - Each incoming data bit is sampled on the rising serial clock.
// - Select 000 writes amp enable, input B and input A selects.
// - Select 010 writes the five fault test mask bits.
// - Select 011 loads gain A, select 100 loads gain B.
// - Power-up runs full diagnostics shut down; writes held until done.
// - Writing fault clear as one ends the power-up run early.
// - Rising edge of diag trigger starts a diagnostic run.
// - One-shot runs once; needs trigger low then high to rerun.
// - Repeat mode reruns 60ms after each run ends until fault, clear cycled, or left.
// - Without a run only thermal and overcurrent faults are watched.
// - Fault stays until fault clear toggles, then outputs return.
// - Current cap select picks fixed or supply-dependent current limit.
// - A masked test raises no flag but still disables the device.
// - Any detected fault disables outputs; an unmasked one also drives fault flag low.
`timescale 1ns/100ps

module wosc_top
  import wosc_pkg::*;
#(
   parameter int unsigned DIAG_CYCLES   = wosc_pkg::DIAG_CYCLES_DEF,
   parameter int unsigned REPEAT_CYCLES = wosc_pkg::REPEAT_CYCLES_DEF,
   parameter int          CNT_W         = 32
) (
   // System clock, reset and enable
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   // Serial link
   input  wire logic                  scl,
   input  wire logic                  sda_i,
   output logic                       sda_o,
   output logic                       sda_oe,
   // Address strap
   input  wire logic                  addr_strap,
   // Fault senses from the output stage
   input  wire wosc_pkg::wosc_fault_t fault_sense,
   // Control outputs
   output wosc_pkg::wosc_ctrl_t       ctrl_o,
   output logic                       amp_out_enable,
   output logic                       diag_active,
   // Open-drain fault flag
   output logic                       fault_flag_n_o,
   output logic                       fault_flag_n_oe
);

   import wosc_pkg::*;

   // Elaboration checks
   if (CNT_W < 2 || CNT_W > 32) begin : g_chk_w
      $error("CNT_W out of range");
   end
   if (DIAG_CYCLES < 1 || REPEAT_CYCLES < 1) begin : g_chk_min
      $error("cycle counts must be at least one");
   end
   if (CNT_W < 32 &&
       (64'(DIAG_CYCLES) >= (64'h1 << CNT_W) ||
        64'(REPEAT_CYCLES) >= (64'h1 << CNT_W))) begin : g_chk_max
      $error("cycle count does not fit the counter");
   end

   localparam logic [CNT_W-1:0] DIAG_LAST   = CNT_W'(DIAG_CYCLES - 1);
   localparam logic [CNT_W-1:0] REPEAT_LAST = CNT_W'(REPEAT_CYCLES - 1);

   function automatic logic [2:0] sel_of(input logic [7:0] b);
      return b[SEL_MSB:SEL_LSB];
   endfunction

   function automatic logic is_clear_write(input logic [7:0] b);
      return (sel_of(b) == SEL_DIAG) && b[DIAG_CLR_BIT];
   endfunction

   // Link clock domain: bit capture
   logic [BYTE_BITS-1:0] link_shift_reg;

   always_ff @(posedge scl) begin
      link_shift_reg <= {link_shift_reg[BYTE_BITS-2:0], sda_i};
   end

   // Synchronisers into the system clock domain
   logic [1:0]           scl_sy_reg;
   logic [1:0]           sda_sy_reg;
   logic                 scl_d_reg;
   logic                 sda_d_reg;
   logic [BYTE_BITS-1:0] word_s1_reg;
   logic [BYTE_BITS-1:0] word_s2_reg;
   logic [1:0]           strap_sy_reg;
   logic [FAULT_W-1:0]   fault_s1_reg;
   logic [FAULT_W-1:0]   fault_s2_reg;

   // Oversampling a 400kHz clock at mclk leaves ample margin
   always_ff @(posedge mclk) begin
      if (rst) begin
         scl_sy_reg   <= 2'h3;
         sda_sy_reg   <= 2'h3;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
         word_s1_reg  <= '0;
         word_s2_reg  <= '0;
         strap_sy_reg <= 2'h0;
         fault_s1_reg <= '0;
         fault_s2_reg <= '0;
      end else if (ce) begin
         scl_sy_reg   <= {scl_sy_reg[0], scl};
         sda_sy_reg   <= {sda_sy_reg[0], sda_i};
         scl_d_reg    <= scl_sy_reg[1];
         sda_d_reg    <= sda_sy_reg[1];
         word_s1_reg  <= link_shift_reg;
         word_s2_reg  <= word_s1_reg;
         strap_sy_reg <= {strap_sy_reg[0], addr_strap};
         fault_s1_reg <= fault_sense;
         fault_s2_reg <= fault_s1_reg;
      end
   end

   // Bus conditions; only master-driven edges matter here
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic addr_ok;

   assign scl_rise  = scl_sy_reg[1] & ~scl_d_reg;
   assign scl_fall  = ~scl_sy_reg[1] & scl_d_reg;
   assign start_det = scl_sy_reg[1] & scl_d_reg & sda_d_reg & ~sda_sy_reg[1];
   assign stop_det  = scl_sy_reg[1] & scl_d_reg & ~sda_d_reg & sda_sy_reg[1];
   assign addr_ok   = (word_s2_reg[ADDR_PFX_MSB:ADDR_PFX_LSB] == ADDR_PREFIX)
                    && (word_s2_reg[ADDR_STRAP_BIT] == strap_sy_reg[1])
                    && !word_s2_reg[ADDR_RW_BIT];

   // Bus protocol
   wosc_bus_t            bus_state_reg;
   logic [3:0]           bit_cnt_reg;
   logic                 ack_oe_reg;
   logic                 byte_stb_reg;
   logic [BYTE_BITS-1:0] byte_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_state_reg <= BUS_IDLE;
         bit_cnt_reg   <= 4'h0;
         ack_oe_reg    <= 1'b0;
         byte_stb_reg  <= 1'b0;
         byte_reg      <= '0;
      end else if (ce) begin
         byte_stb_reg <= 1'b0;
         if (start_det) begin
            bus_state_reg <= BUS_ADDR;
            bit_cnt_reg   <= 4'h0;
            ack_oe_reg    <= 1'b0;
         end else if (stop_det) begin
            bus_state_reg <= BUS_IDLE;
            ack_oe_reg    <= 1'b0;
         end else begin
            unique case (bus_state_reg)
               BUS_ADDR, BUS_DATA: begin
                  if (scl_rise) begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == BIT_CNT_END) begin
                     bit_cnt_reg <= 4'h0;
                     if (bus_state_reg == BUS_DATA) begin
                        ack_oe_reg    <= 1'b1;
                        byte_reg      <= word_s2_reg;
                        byte_stb_reg  <= 1'b1;
                        bus_state_reg <= BUS_DATA_ACK;
                     end else if (addr_ok) begin
                        ack_oe_reg    <= 1'b1;
                        bus_state_reg <= BUS_ADDR_ACK;
                     end else begin
                        bus_state_reg <= BUS_WAIT_STOP;
                     end
                  end
               end
               BUS_ADDR_ACK: begin
                  if (scl_fall) begin
                     ack_oe_reg    <= 1'b0;
                     bus_state_reg <= BUS_DATA;
                  end
               end
               BUS_DATA_ACK: begin
                  if (scl_fall) begin
                     ack_oe_reg    <= 1'b0;
                     bus_state_reg <= BUS_WAIT_STOP;
                  end
               end
               BUS_IDLE, BUS_WAIT_STOP: begin
                  bit_cnt_reg <= 4'h0;
               end
            endcase
         end
      end
   end

   // Register file: writes land in a held copy first
   wosc_ctrl_t pend_reg;
   wosc_ctrl_t ctrl_reg;
   wosc_seq_t  seq_state_reg;
   logic [PAY_MSB:0] pay;

   assign pay = byte_reg[PAY_MSB:0];

   always_ff @(posedge mclk) begin
      if (rst) begin
         pend_reg <= CTRL_RESET;
      end else if (ce && byte_stb_reg) begin
         unique case (sel_of(byte_reg))
            SEL_MODE: begin
               pend_reg.amp_enable <= pay[MODE_AMP_EN_BIT];
               pend_reg.audio_in_b <= pay[MODE_IN_B_BIT];
               pend_reg.audio_in_a <= pay[MODE_IN_A_BIT];
            end
            SEL_DIAG: begin
               pend_reg.diag_trigger       <= pay[DIAG_TRIG_BIT];
               pend_reg.diag_repeat_mode   <= pay[DIAG_REP_BIT];
               pend_reg.fault_clear        <= pay[DIAG_CLR_BIT];
               pend_reg.current_cap_select <= pay[DIAG_CAP_BIT];
            end
            SEL_MASK: begin
               pend_reg.fault_mask <= pay;
            end
            SEL_GAIN_A: begin
               pend_reg.gain_a_level <= pay;
            end
            SEL_GAIN_B: begin
               pend_reg.gain_b_level <= pay;
            end
            default: begin
               pend_reg <= pend_reg;
            end
         endcase
      end
   end

   // Held writes take effect once the power-up run is over
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (ce && seq_state_reg != SEQ_POWERUP) begin
         ctrl_reg <= pend_reg;
      end
   end

   // Edges of the live trigger and clear bits
   logic trig_prev_reg;
   logic clr_prev_reg;
   logic trig_rise;
   logic clr_rise;
   logic clear_abort;

   always_ff @(posedge mclk) begin
      if (rst) begin
         trig_prev_reg <= 1'b0;
         clr_prev_reg  <= 1'b0;
      end else if (ce) begin
         trig_prev_reg <= ctrl_reg.diag_trigger;
         clr_prev_reg  <= ctrl_reg.fault_clear;
      end
   end

   assign trig_rise   = ctrl_reg.diag_trigger & ~trig_prev_reg;
   assign clr_rise    = ctrl_reg.fault_clear & ~clr_prev_reg;
   assign clear_abort = byte_stb_reg & is_clear_write(byte_reg);

   // Fault detection
   logic [FAULT_W-1:0] watch;
   logic [FAULT_W-1:0] detected;
   logic               protect_event;
   logic               flag_event;
   logic               diag_on;

   assign diag_on       = (seq_state_reg == SEQ_POWERUP)
                       || (seq_state_reg == SEQ_RUN);
   assign watch         = diag_on ? (FAULT_ALWAYS | FAULT_DIAG)
                                  : FAULT_ALWAYS;
   assign detected      = fault_s2_reg & watch;
   assign protect_event = |detected;
   assign flag_event    = |(detected & ~ctrl_reg.fault_mask);

   // Diagnostic sequencer
   logic [CNT_W-1:0] seq_cnt_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         seq_state_reg <= SEQ_POWERUP;
         seq_cnt_reg   <= '0;
      end else if (ce) begin
         unique case (seq_state_reg)
            SEQ_POWERUP: begin
               if (clear_abort || seq_cnt_reg == DIAG_LAST) begin
                  seq_state_reg <= SEQ_IDLE;
                  seq_cnt_reg   <= '0;
               end else begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
               end
            end
            SEQ_IDLE: begin
               seq_cnt_reg <= '0;
               if (trig_rise) begin
                  seq_state_reg <= SEQ_RUN;
               end
            end
            SEQ_RUN: begin
               if (protect_event || clr_rise) begin
                  seq_state_reg <= SEQ_IDLE;
                  seq_cnt_reg   <= '0;
               end else if (seq_cnt_reg == DIAG_LAST) begin
                  seq_cnt_reg <= '0;
                  if (ctrl_reg.diag_repeat_mode) begin
                     seq_state_reg <= SEQ_WAIT;
                  end else begin
                     seq_state_reg <= SEQ_IDLE;
                  end
               end else begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
               end
            end
            SEQ_WAIT: begin
               if (protect_event || clr_rise ||
                   !ctrl_reg.diag_repeat_mode) begin
                  seq_state_reg <= SEQ_IDLE;
                  seq_cnt_reg   <= '0;
               end else if (seq_cnt_reg == REPEAT_LAST) begin
                  seq_state_reg <= SEQ_RUN;
                  seq_cnt_reg   <= '0;
               end else begin
                  seq_cnt_reg <= seq_cnt_reg + 1'b1;
               end
            end
         endcase
      end
   end

   // Fault latches; a new fault beats a clear in the same cycle
   logic protect_reg;
   logic flag_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         protect_reg <= 1'b0;
         flag_reg    <= 1'b0;
      end else if (ce) begin
         if (protect_event) begin
            protect_reg <= 1'b1;
         end else if (clr_rise) begin
            protect_reg <= 1'b0;
         end
         if (flag_event) begin
            flag_reg <= 1'b1;
         end else if (clr_rise) begin
            flag_reg <= 1'b0;
         end
      end
   end

   // Registered outputs
   logic amp_en_reg;
   logic diag_act_reg;
   logic flag_oe_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         amp_en_reg   <= 1'b0;
         diag_act_reg <= 1'b1;
         flag_oe_reg  <= 1'b0;
      end else if (ce) begin
         amp_en_reg   <= ctrl_reg.amp_enable && !protect_reg
                      && !protect_event
                      && seq_state_reg != SEQ_POWERUP;
         diag_act_reg <= diag_on;
         flag_oe_reg  <= flag_reg | flag_event;
      end
   end

   // Data pin and fault pin only ever pull low
   logic low_drive_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         low_drive_reg <= 1'b0;
      end else if (ce) begin
         low_drive_reg <= 1'b0;
      end
   end

   assign sda_o           = low_drive_reg;
   assign sda_oe          = ack_oe_reg;
   assign fault_flag_n_o  = low_drive_reg;
   assign fault_flag_n_oe = flag_oe_reg;
   assign ctrl_o          = ctrl_reg;
   assign amp_out_enable  = amp_en_reg;
   assign diag_active     = diag_act_reg;

endmodule

// file: wosc_chk_sva.sv
// Concurrent checks on the ports of wosc_top.
// Assumes one mclk domain with synchronous active-high reset rst.
`timescale 1ns/100ps

module wosc_chk #(
   parameter int unsigned DIAG_CYCLES = 200
) (
   // Clock, reset and enable
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire logic                  ce,
   // Serial link and strap
   input wire logic                  scl,
   input wire logic                  sda_i,
   input wire logic                  sda_o,
   input wire logic                  sda_oe,
   input wire logic                  addr_strap,
   // Faults and controls
   input wire wosc_pkg::wosc_fault_t fault_sense,
   input wire wosc_pkg::wosc_ctrl_t  ctrl_o,
   input wire logic                  amp_out_enable,
   input wire logic                  diag_active,
   input wire logic                  fault_flag_n_o,
   input wire logic                  fault_flag_n_oe
);
   import wosc_pkg::*;
   logic        pwr_reg;
   logic [31:0] run_reg;

   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // Power-up run in progress
   always_ff @(posedge mclk) begin
      if (rst)
         pwr_reg <= 1'b1;
      else if (!diag_active)
         pwr_reg <= 1'b0;
   end

   // Length of the current run
   always_ff @(posedge mclk) begin
      if (rst || !diag_active)
         run_reg <= 32'h0;
      else
         run_reg <= run_reg + 32'h1;
   end

   a_ack_scl_low: assert property (
      $changed(sda_oe) |-> !scl) else $error("ack moved with scl high");
   a_ack_low: assert property (
      sda_oe |-> !sda_o) else $error("ack drives sda high");
   a_flag_od: assert property (
      fault_flag_n_oe |-> !fault_flag_n_o) else $error("flag driven high");
   a_fault_off: assert property (
      fault_flag_n_oe |-> !amp_out_enable) else $error("amp on with fault");
   a_pwrup_shut: assert property (
      pwr_reg && diag_active |-> !amp_out_enable)
      else $error("amp on during power-up");
   a_trig_start: assert property (
      $rose(ctrl_o.diag_trigger) && !diag_active && !pwr_reg
      |-> ##[1:2] diag_active) else $error("trigger edge started no run");
   a_run_bound: assert property (
      diag_active |-> run_reg <= DIAG_CYCLES + 1)
      else $error("diagnostic run too long");
   a_flag_raise: assert property (
      fault_sense.thermal && !ctrl_o.fault_mask[4]
      |-> ##[1:5] fault_flag_n_oe) else $error("thermal fault not flagged");
   a_prot_off: assert property (
      fault_sense.thermal [*5] |-> !amp_out_enable)
      else $error("protection did not disable amp");
   a_clear_flag: assert property (
      $rose(ctrl_o.fault_clear) && fault_sense == '0
      && $past(fault_sense, 3) == '0 |-> ##[1:3] !fault_flag_n_oe)
      else $error("fault clear left flag low");

   c_ack: cover property ($rose(sda_oe));
   c_run_end: cover property ($fell(diag_active));
   c_fault: cover property ($rose(fault_flag_n_oe));
endmodule

bind wosc_top wosc_chk #(.DIAG_CYCLES(DIAG_CYCLES)) u_chk (
   .mclk(mclk), .rst(rst), .ce(ce), .scl(scl), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap(addr_strap),
   .fault_sense(fault_sense), .ctrl_o(ctrl_o),
   .amp_out_enable(amp_out_enable), .diag_active(diag_active),
   .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe(fault_flag_n_oe)
);

// file: wosc_master.sv
// Two-wire bus master model driving scl and its side of sda.
// Assumes sda is the resolved wire with a pull-up; released reads 1.
`timescale 1ns/100ps

module wosc_master #(
   parameter int H = 1250
) (
   // Serial link
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end

   // One clock: data set mid-low, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      #(H/2) sda_m = b;
      #(H/2) scl = 1'b1;
      #(H/2) r = sda;
      #(H/2) scl = 1'b0;
   endtask

   task automatic byte_io(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   task automatic xfer(input logic [6:0] a, input logic rw,
                       input logic [7:0] d, output logic ack_a,
                       output logic ack_d);
      ack_d = 1'b0;
      #H sda_m = 1'b0;
      #H scl = 1'b0;
      byte_io({a, rw}, ack_a);
      if (ack_a && !rw)
         byte_io(d, ack_d);
      #(H/2) sda_m = 1'b0;
      #(H/2) scl = 1'b1;
      #H sda_m = 1'b1;
      #H;
   endtask
endmodule

// file: tb.sv
// Self-checking bench for wosc_top with a master model on the link.
// Assumes a pull-up on sda and shortened diagnostic counts.
`timescale 1ns/100ps

`define CHK(a, e) \
   begin \
      num_checks++; \
      if ((a) !== (e)) begin \
         num_errors++; \
         $display("Error t=%0t got %h exp %h", $time, (a), (e)); \
      end \
   end

module tb;
   import wosc_pkg::*;
   localparam int unsigned DC = 3000;
   localparam int unsigned RC = 300;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        addr_strap = 1'b0;
   wosc_fault_t fault_sense = '0;
   wosc_ctrl_t  ctrl_o;
   wosc_ctrl_t  exp_c;
   logic        scl, sda_m, sda, sda_o, sda_oe;
   logic        amp_out_enable, diag_active, flag_o, flag_oe;
   logic        ack_a, ack_d;
   logic [7:0]  d;
   int          num_errors = 0;
   int          num_checks = 0;
   // Data byte, expected address ack
   logic [8:0]  rows [8] = '{9'h11c, 9'h15f, 9'h17f, 9'h195,
                             9'h1bf, 9'h1ff, 9'h140, 9'h110};
   // Strap, address, rw, expected ack
   logic [9:0]  arows [4] = '{{1'b0, 7'h7d, 2'h0}, {1'b0, 7'h7c, 2'h2},
                              {1'b1, 7'h7d, 2'h1}, {1'b1, 7'h7c, 2'h0}};

   assign sda = sda_m & !(sda_oe & !sda_o);
   always #5 mclk = ~mclk;

   wosc_top #(.DIAG_CYCLES(DC), .REPEAT_CYCLES(RC)) u_dut (
      .mclk(mclk), .rst(rst), .ce(1'b1), .scl(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap(addr_strap),
      .fault_sense(fault_sense), .ctrl_o(ctrl_o),
      .amp_out_enable(amp_out_enable), .diag_active(diag_active),
      .fault_flag_n_o(flag_o), .fault_flag_n_oe(flag_oe));

   // 500 ns phases keep each phase near 50 mclk cycles for the oversampler
   wosc_master #(.H(500)) u_mst (.scl(scl), .sda_m(sda_m), .sda(sda));

   function automatic wosc_ctrl_t apply(input wosc_ctrl_t c,
                                        input logic [7:0] b);
      case (b[7:5])
         SEL_MODE: {c.amp_enable, c.audio_in_b, c.audio_in_a} = b[4:2];
         SEL_DIAG: {c.diag_trigger, c.diag_repeat_mode, c.fault_clear,
                    c.current_cap_select} = b[4:1];
         SEL_MASK: c.fault_mask = b[4:0];
         SEL_GAIN_A: c.gain_a_level = b[4:0];
         SEL_GAIN_B: c.gain_b_level = b[4:0];
         default: c = c;
      endcase
      return c;
   endfunction

   task automatic send(input logic [7:0] b);
      u_mst.xfer(7'h7c, 1'b0, b, ack_a, ack_d);
      @(negedge mclk);
      exp_c = apply(exp_c, b);
      `CHK(ack_d, 1'b1)
   endtask

   task automatic wait_diag(input logic lvl, input int lim);
      for (int n = 0; n < lim && diag_active !== lvl; n++)
         @(negedge mclk);
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Whole run is near 50k cycles
   initial begin
      #(90_000 * 10);
      num_errors++;
      final_report();
   end

   initial begin
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      `CHK(diag_active, 1'b1)
      `CHK(ctrl_o, CTRL_RESET)
      `CHK({sda_oe, amp_out_enable, flag_oe}, 3'h0)
      `CHK({sda_o, flag_o}, 2'h0)
      exp_c = CTRL_RESET;
      send(8'h1c);
      `CHK(diag_active, 1'b1)
      `CHK(ctrl_o, CTRL_RESET)
      wait_diag(1'b0, DC);
      repeat (5) @(negedge mclk);
      `CHK(ctrl_o, exp_c)
      tend("powerup");
      for (int i = 0; i < 8; i++) begin
         send(rows[i][7:0]);
         `CHK(ack_a, rows[i][8])
         `CHK(ctrl_o, exp_c)
      end
      tend("rows");
      for (int i = 0; i < 4; i++) begin
         addr_strap = arows[i][9];
         d = 8'(8'h61 + i);
         repeat (4) @(negedge mclk);
         u_mst.xfer(arows[i][8:2], arows[i][1], d, ack_a, ack_d);
         @(negedge mclk);
         if (arows[i][0])
            exp_c = apply(exp_c, d);
         `CHK(ack_a, arows[i][0])
         `CHK(ctrl_o, exp_c)
      end
      addr_strap = 1'b0;
      tend("address");
      fault_sense.thermal = 1'b1;
      repeat (10) @(negedge mclk);
      `CHK({amp_out_enable, flag_oe}, 2'h1)
      fault_sense.thermal = 1'b0;
      repeat (10) @(negedge mclk);
      `CHK({amp_out_enable, flag_oe}, 2'h1)
      send(8'h24);
      `CHK({amp_out_enable, flag_oe}, 2'h2)
      send(8'h50);
      fault_sense.thermal = 1'b1;
      repeat (10) @(negedge mclk);
      `CHK({amp_out_enable, flag_oe}, 2'h0)
      fault_sense.thermal = 1'b0;
      send(8'h20);
      send(8'h24);
      `CHK({amp_out_enable, flag_oe}, 2'h2)
      fault_sense.supply_short = 1'b1;
      repeat (10) @(negedge mclk);
      `CHK({amp_out_enable, flag_oe}, 2'h2)
      fault_sense.supply_short = 1'b0;
      tend("faults");
      send(8'h30);
      `CHK(diag_active, 1'b1)
      wait_diag(1'b0, DC + 10);
      repeat (RC + 50) @(negedge mclk);
      `CHK(diag_active, 1'b0)
      send(8'h30);
      `CHK(diag_active, 1'b0)
      send(8'h28);
      send(8'h38);
      `CHK(diag_active, 1'b1)
      wait_diag(1'b0, DC + 10);
      wait_diag(1'b1, RC + 10);
      `CHK(diag_active, 1'b1)
      fault_sense.supply_short = 1'b1;
      repeat (10) @(negedge mclk);
      `CHK({amp_out_enable, flag_oe}, 2'h1)
      fault_sense.supply_short = 1'b0;
      wait_diag(1'b0, DC + 10);
      repeat (RC + 50) @(negedge mclk);
      `CHK(diag_active, 1'b0)
      tend("diagnostics");
      rst = 1'b1;
      repeat (12) @(negedge mclk);
      rst = 1'b0;
      exp_c = CTRL_RESET;
      send(8'h24);
      `CHK(diag_active, 1'b0)
      `CHK(ctrl_o, exp_c)
      tend("early end");
      final_report();
   end
endmodule
